// [rtl/nvmpu_top.sv]
// Operation
// - flash operand lock exempts flash/boot fetches
// - boot operand lock exempts boot fetches
// - eeprom lock exempts boot/flash/eeprom fetches
// - external fetch lock blocks internal operands
// - access register at 231ffc, delivery ff
// - wrong password burns one attempt bit
// - test mode bypasses locks when enabled
// - password write clears test-mode-disable bit
// - matching password clears password-ok bit
// - boot write lock never temporarily lifted
// - eeprom write lock lifted by set op
// - four sector write locks, liftable
// - write register at 231ffd, status bits
// - password bytes write-only, written once
// - external lock lifted from ram/eeprom only
// - eeprom lock lifted from eeprom only
// - direct write lifts flash/boot lock
// - reset or set-op zero restores locks
// - dma read of locked memory gives ff
// - reset forces locks, then loads them
`timescale 1ns/1ps
`default_nettype none
module nvmpu_top
    import nvmpu_pkg::*;
#(
    parameter int LOAD_N = nvmpu_pkg::LOAD_CYCLES,
    parameter logic [23:0] FLASH_LO = 24'h00_0000,
    parameter logic [23:0] FLASH_HI = 24'h01_ffff,
    parameter logic [23:0] RAM_LO = 24'h20_0000,
    parameter logic [23:0] RAM_HI = 24'h20_0fff,
    parameter logic [23:0] EE_LO = 24'h22_0000,
    parameter logic [23:0] EE_HI = 24'h22_03ff,
    parameter logic [23:0] BOOT_LO = 24'h23_0000,
    parameter logic [23:0] BOOT_HI = 24'h23_1fff,
    parameter int SECT_LSB = 15
)
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic por_i,
    input wire logic test_mode_i,
    input wire logic direct_unprot_cfg_i,
    input wire logic [23:0] fetch_addr_i,
    input wire logic op_valid_i,
    input wire logic op_we_i,
    input wire logic [23:0] op_addr_i,
    input wire logic [7:0] op_wdata_i,
    input wire logic pset_valid_i,
    input wire logic [3:0] pset_en_i,
    input wire logic [31:0] pset_data_i,
    input wire logic dma_rd_i,
    input wire logic [23:0] dma_addr_i,
    input wire logic [7:0] dma_mem_rdata_i,
    output logic op_allow_o,
    output logic op_deny_o,
    output logic op_rvalid_o,
    output logic [7:0] op_rdata_o,
    output logic pset_done_o,
    output logic pset_refused_o,
    output logic dma_deny_o,
    output logic dma_rvalid_o,
    output logic [7:0] dma_rdata_o,
    output logic [7:0] ap_o,
    output logic [7:0] wp_o,
    output logic test_mode_en_o,
    output logic ready_o
);
    typedef struct packed {
        nvmpu_state_t st;
        logic [7:0] cnt;
        logic [7:0] ap;
        logic [7:0] wp;
        logic op_rvalid;
        logic [7:0] op_rdata;
        logic pset_done;
        logic pset_ref;
        logic dma_rvalid;
        logic [7:0] dma_rdata;
    } nvmpu_state_s_t;

    nvmpu_state_s_t s_r;
    nvmpu_state_s_t s_nxt;

    // memory class of each address input
    nvmpu_region_t fetch_rg;
    nvmpu_region_t op_rg;
    nvmpu_region_t dma_rg;

    // cell contents and the program strobes into the store
    logic [7:0] nv_ap;
    logic [7:0] nv_wp;
    logic [15:0] nv_pw;
    logic nv_pw_set;
    logic [7:0] ap_clr;
    logic [7:0] wp_clr;
    logic pw_wr;

    // gate results and status views
    logic bypass;
    logic cpu_deny;
    logic dma_deny;
    logic [7:0] ap_view;
    logic [7:0] wp_view;
    logic [ATTEMPT_W-1:0] attempts;

    // byte lanes of the protection-set data
    logic [7:0] pset_ap;
    logic [7:0] pset_wp;
    logic [15:0] pset_pw;

    // ==========================================
    // address decode into memory classes
    // test order sets priority should two ranges ever overlap
    function automatic nvmpu_region_t decode(input logic [23:0] a);
        if (a >= FLASH_LO && a <= FLASH_HI)
            return RG_FLASH;
        else if (a >= EE_LO && a <= EE_HI)
            return RG_EE;
        else if (a >= BOOT_LO && a <= BOOT_HI)
            return RG_BOOT;
        else if (a >= RAM_LO && a <= RAM_HI)
            return RG_RAM;
        else
            return RG_EXT;
    endfunction

    assign fetch_rg = decode(fetch_addr_i);
    assign op_rg = decode(op_addr_i);
    assign dma_rg = decode(dma_addr_i);

    // ==========================================
    // nonvolatile cells and test-mode state
    nvmpu_nv_store u_nv
    (
        .clk_sys_i(clk_sys_i),
        .por_i(por_i),
        .ap_clr_i(ap_clr),
        .wp_clr_i(wp_clr),
        .pw_wr_i(pw_wr),
        .pw_data_i(pset_pw),
        .ap_o(nv_ap),
        .wp_o(nv_wp),
        .pw_o(nv_pw),
        .pw_set_o(nv_pw_set)
    );

    // attempt bits are read straight from the cell
    assign attempts = nv_ap[ATTEMPT_W-1:0];
    // a cleared password-ok bit overrides the disable bit
    // with every attempt burnt no compare runs, so a disable is final
    assign test_mode_en_o = nv_wp[WP_TEST_DIS] | ~nv_wp[WP_PW_MATCH];
    assign bypass = test_mode_i & test_mode_en_o;

    // access lock bits 6:3 and write bits 5:0 show the working copy
    // access bits 7 and 2:0 and write bits 7:6 show the cells
    assign ap_view = {nv_ap[7], s_r.ap[6:3], attempts};
    assign wp_view = {nv_wp[7:6], s_r.wp[5:0]};

    // byte lanes of one protection-set operation
    assign pset_ap = pset_data_i[8*IDX_AP +: 8];
    assign pset_wp = pset_data_i[8*IDX_WP +: 8];
    assign pset_pw = {pset_data_i[8*IDX_PWH +: 8], pset_data_i[8*IDX_PWL +: 8]};

    // ==========================================
    // access gates: processor operand and peripheral dma
    // the sector index only matters for a flash target
    nvmpu_gate u_cpu_gate
    (
        .src_i(fetch_rg),
        .dst_i(op_rg),
        .sect_i(op_addr_i[SECT_LSB +: 2]),
        .we_i(op_we_i),
        .ap_i(s_r.ap),
        .wp_i(s_r.wp),
        .bypass_i(bypass),
        .deny_o(cpu_deny)
    );

    // dma never writes here, and has no fetch source to exempt it
    nvmpu_gate u_dma_gate
    (
        .src_i(RG_NONE),
        .dst_i(dma_rg),
        .sect_i(dma_addr_i[SECT_LSB +: 2]),
        .we_i(1'b0),
        .ap_i(s_r.ap),
        .wp_i(s_r.wp),
        .bypass_i(bypass),
        .deny_o(dma_deny)
    );

    // ==========================================
    // next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.op_rvalid = 1'b0;
        s_nxt.pset_done = 1'b0;
        s_nxt.pset_ref = 1'b0;
        s_nxt.dma_rvalid = 1'b0;
        ap_clr = 8'h00;
        wp_clr = 8'h00;
        pw_wr = 1'b0;
        case (s_r.st)
            ST_INIT:
            begin
                // locks held active while the cells are read
                // a longer count only delays ready; the gates stay shut
                s_nxt.ap = LOCKED;
                s_nxt.wp = LOCKED;
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == 8'(LOAD_N - 1))
                    s_nxt.st = ST_LOAD;
            end
            ST_LOAD:
            begin
                // all cells copied into the working locks in one step
                s_nxt.ap = nv_ap;
                s_nxt.wp = nv_wp;
                s_nxt.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (pset_valid_i)
                begin
                    if (fetch_rg inside {RG_FLASH, RG_BOOT})
                        s_nxt.pset_ref = 1'b1;
                    else
                    begin
                        s_nxt.pset_done = 1'b1;
                        if (pset_en_i[IDX_AP])
                        begin
                            // zeros program the cells and restore the locks
                            ap_clr = ~pset_ap & AP_USER_MASK;
                            s_nxt.ap = s_r.ap & ~ap_clr;
                            if (pset_ap[AP_EXT] && fetch_rg inside {RG_EE, RG_RAM})
                                s_nxt.ap[AP_EXT] = 1'b1;
                            if (pset_ap[AP_EE] && fetch_rg == RG_EE)
                                s_nxt.ap[AP_EE] = 1'b1;
                        end
                        if (pset_en_i[IDX_WP])
                        begin
                            wp_clr = ~pset_wp & WP_USER_MASK;
                            // lifts change the working copy only
                            s_nxt.wp[4:0] = pset_wp[4:0];
                            if (!pset_wp[WP_BOOT])
                                s_nxt.wp[WP_BOOT] = 1'b0;
                        end
                        if (pset_en_i[IDX_PWL] && pset_en_i[IDX_PWH])
                        begin
                            // the first paired write stores the password, later ones compare
                            if (!nv_pw_set)
                                pw_wr = 1'b1;
                            else if (!nv_wp[WP_TEST_DIS] && nv_wp[WP_PW_MATCH] && |attempts)
                            begin
                                // once matched, further compares could only burn attempts
                                if (pset_pw == nv_pw)
                                    wp_clr[WP_PW_MATCH] = 1'b1;
                                else
                                    // burn the highest attempt still left
                                    ap_clr[ATTEMPT_W-1:0] = attempts & ~(attempts >> 1);
                            end
                        end
                    end
                end
                // the operand gate does not apply; only the fetch source decides
                if (op_valid_i && op_we_i && op_addr_i == ADDR_AP && direct_unprot_cfg_i)
                begin
                    if (op_wdata_i[AP_FLASH] && fetch_rg == RG_FLASH)
                        s_nxt.ap[AP_FLASH] = 1'b1;
                    if (op_wdata_i[AP_BOOT] && fetch_rg == RG_BOOT)
                        s_nxt.ap[AP_BOOT] = 1'b1;
                end
                if (op_valid_i && !op_we_i && !cpu_deny)
                begin
                    s_nxt.op_rvalid = 1'b1;
                    case (op_addr_i)
                        ADDR_AP: s_nxt.op_rdata = ap_view;
                        ADDR_WP: s_nxt.op_rdata = wp_view;
                        default: s_nxt.op_rdata = DELIVERY;
                    endcase
                end
            end
            default:
            begin
                s_nxt.st = ST_INIT;
            end
        endcase
        // dma read data: locked memory reads as all ones
        // it runs in every state, so a read during load sees locked memory
        if (dma_rd_i)
        begin
            s_nxt.dma_rvalid = 1'b1;
            s_nxt.dma_rdata = dma_deny ? DELIVERY : dma_mem_rdata_i;
        end
    end

    // ==========================================
    // state register; warm reset re-runs the load sequence
    // working copies are volatile, so every temporary lift ends here
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            s_r.st <= ST_INIT;
            s_r.cnt <= 8'h00;
            s_r.ap <= LOCKED;
            s_r.wp <= LOCKED;
            s_r.op_rvalid <= 1'b0;
            s_r.op_rdata <= 8'h00;
            s_r.pset_done <= 1'b0;
            s_r.pset_ref <= 1'b0;
            s_r.dma_rvalid <= 1'b0;
            s_r.dma_rdata <= 8'h00;
        end
        else
            s_r <= s_nxt;
    end

    // ==========================================
    // outputs
    // the decisions are combinational so the core can drop the access at once
    assign op_allow_o = op_valid_i & ~cpu_deny;
    assign op_deny_o = op_valid_i & cpu_deny;
    assign dma_deny_o = dma_rd_i & dma_deny;

    // answers registered one cycle after the request
    assign op_rvalid_o = s_r.op_rvalid;
    assign op_rdata_o = s_r.op_rdata;
    assign pset_done_o = s_r.pset_done;
    assign pset_refused_o = s_r.pset_ref;
    assign dma_rvalid_o = s_r.dma_rvalid;
    assign dma_rdata_o = s_r.dma_rdata;

    // status views; ready stays low through forcing and load
    assign ap_o = ap_view;
    assign wp_o = wp_view;
    assign ready_o = (s_r.st == ST_RUN);
endmodule // nvmpu_top
`default_nettype wire

// [rtl/nvmpu_pkg.sv]
package nvmpu_pkg;

    // ==========================================
    // register locations in the boot test flash
    localparam logic [23:0] ADDR_AP = 24'h23_1ffc;
    localparam logic [23:0] ADDR_WP = 24'h23_1ffd;
    localparam logic [23:0] ADDR_PWL = 24'h23_1ffe;
    localparam logic [23:0] ADDR_PWH = 24'h23_1fff;
    localparam logic [7:0] DELIVERY = 8'hff;
    localparam logic [7:0] LOCKED = 8'h00;

    // ==========================================
    // field positions
    localparam int AP_FLASH = 6;
    localparam int AP_BOOT = 5;
    localparam int AP_EE = 4;
    localparam int AP_EXT = 3;
    localparam int WP_TEST_DIS = 7;
    localparam int WP_PW_MATCH = 6;
    localparam int WP_BOOT = 5;
    localparam int WP_EE = 4;
    localparam int ATTEMPT_W = 3;
    localparam int SECT_N = 4;
    localparam logic [7:0] AP_USER_MASK = 8'h78;
    localparam logic [7:0] WP_USER_MASK = 8'h3f;

    // ==========================================
    // protection-set byte lanes
    localparam int IDX_AP = 0;
    localparam int IDX_WP = 1;
    localparam int IDX_PWL = 2;
    localparam int IDX_PWH = 3;

    // ==========================================
    // timing: length of the forced-protection phase
    localparam int LOAD_CYCLES = 4;

    typedef enum logic [5:0] {
        RG_NONE = 6'h01,
        RG_FLASH = 6'h02,
        RG_BOOT = 6'h04,
        RG_EE = 6'h08,
        RG_RAM = 6'h10,
        RG_EXT = 6'h20
    } nvmpu_region_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_LOAD = 3'h2,
        ST_RUN = 3'h4
    } nvmpu_state_t;

endpackage

// [rtl/nvmpu_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module nvmpu_gate
    import nvmpu_pkg::*;
(
    input wire nvmpu_pkg::nvmpu_region_t src_i,
    input wire nvmpu_pkg::nvmpu_region_t dst_i,
    input wire logic [1:0] sect_i,
    input wire logic we_i,
    input wire logic [7:0] ap_i,
    input wire logic [7:0] wp_i,
    input wire logic bypass_i,
    output logic deny_o
);
    logic internal;
    logic from_code;

    // ==========================================
    // access decision for one operand or dma access
    assign internal = dst_i inside {RG_FLASH, RG_BOOT, RG_EE, RG_RAM};
    assign from_code = src_i inside {RG_FLASH, RG_BOOT};
    // dma uses RG_NONE as source, so no fetch exemption ever helps it
    always_comb
    begin
        deny_o = 1'b0;
        if (dst_i == RG_FLASH && !ap_i[AP_FLASH] && !from_code)
            deny_o = 1'b1;
        if (dst_i == RG_BOOT && !ap_i[AP_BOOT] && src_i != RG_BOOT)
            deny_o = 1'b1;
        if (dst_i == RG_EE && !ap_i[AP_EE] && !from_code && src_i != RG_EE)
            deny_o = 1'b1;
        if (src_i == RG_EXT && !ap_i[AP_EXT] && internal)
            deny_o = 1'b1;
        if (we_i && dst_i == RG_BOOT && !wp_i[WP_BOOT])
            deny_o = 1'b1;
        if (we_i && dst_i == RG_EE && !wp_i[WP_EE])
            deny_o = 1'b1;
        if (we_i && dst_i == RG_FLASH && !wp_i[sect_i])
            deny_o = 1'b1;
        if (bypass_i)
            deny_o = 1'b0;
    end
endmodule // nvmpu_gate
`default_nettype wire

// [rtl/nvmpu_nv_store.sv]
`timescale 1ns/1ps
`default_nettype none
module nvmpu_nv_store
    import nvmpu_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic por_i,
    input wire logic [7:0] ap_clr_i,
    input wire logic [7:0] wp_clr_i,
    input wire logic pw_wr_i,
    input wire logic [15:0] pw_data_i,
    output logic [7:0] ap_o,
    output logic [7:0] wp_o,
    output logic [15:0] pw_o,
    output logic pw_set_o
);
    typedef struct packed {
        logic [7:0] ap;
        logic [7:0] wp;
        logic [15:0] pw;
        logic pw_set;
    } nvmpu_nv_t;

    nvmpu_nv_t s_r;
    nvmpu_nv_t s_nxt;

    // ==========================================
    // one-time cells: a program only ever turns ones into zeros
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ap = s_r.ap & ~ap_clr_i;
        s_nxt.wp = s_r.wp & ~wp_clr_i;
        if (pw_wr_i && !s_r.pw_set)
        begin
            s_nxt.pw = pw_data_i;
            s_nxt.pw_set = 1'b1;
            s_nxt.wp[WP_TEST_DIS] = 1'b0;
        end
    end

    // only power-on restores delivery state; warm reset keeps contents
    always_ff @(posedge clk_sys_i)
    begin
        if (por_i)
            s_r <= '{ap: DELIVERY, wp: DELIVERY, pw: {DELIVERY, DELIVERY}, pw_set: 1'b0};
        else
            s_r <= s_nxt;
    end

    assign ap_o = s_r.ap;
    assign wp_o = s_r.wp;
    assign pw_o = s_r.pw;
    assign pw_set_o = s_r.pw_set;
endmodule // nvmpu_nv_store
`default_nettype wire

// [testbench/nvmpu_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================
// memory behind the dma port
module nvmpu_mem_model (
    input wire logic [23:0] addr_i,
    output logic [7:0] rdata_o
);
    // address-derived pattern, so a stale or forced byte shows up at once
    assign rdata_o = addr_i[7:0] ^ 8'h5a;
endmodule // nvmpu_mem_model
`default_nettype wire

// [testbench/nvmpu_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module nvmpu_checker (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic test_mode_i,
    input wire logic [23:0] fetch_addr_i,
    input wire logic op_valid_i,
    input wire logic op_we_i,
    input wire logic [23:0] op_addr_i,
    input wire logic pset_valid_i,
    input wire logic dma_rd_i,
    input wire logic [7:0] dma_mem_rdata_i,
    input wire logic op_deny_o,
    input wire logic pset_refused_o,
    input wire logic dma_deny_o,
    input wire logic dma_rvalid_o,
    input wire logic [7:0] dma_rdata_o,
    input wire logic [7:0] ap_o,
    input wire logic [7:0] wp_o,
    input wire logic test_mode_en_o,
    input wire logic ready_o
);
    logic [3:0] fr;
    logic [3:0] orr;
    logic byp;
    // region decode {ram, eeprom, boot, flash}; default map of the top module only
    function automatic logic [3:0] rg(input logic [23:0] a);
        rg = {a >= 24'h20_0000 && a <= 24'h20_0fff, a >= 24'h22_0000 && a <= 24'h22_03ff,
              a >= 24'h23_0000 && a <= 24'h23_1fff, a <= 24'h01_ffff};
    endfunction
    assign fr = rg(fetch_addr_i);
    assign orr = rg(op_addr_i);
    assign byp = test_mode_i & test_mode_en_o;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // =====================
    // multi-step behaviours
    sequence s_dma_ff;
        dma_rvalid_o && dma_rdata_o == 8'hff;
    endsequence
    sequence s_load;
        !ready_o [*3] ##[1:8] ready_o;
    endsequence
    // =====================
    // gate relations, dma data, reset, load timing and pset refusal
    a_flash_op_lock: assert property (
        op_valid_i && !byp && !ap_o[6] && orr[0] && fr[1:0] == 2'b00 |-> op_deny_o)
        else $error("flash operand not blocked");
    a_boot_op_lock: assert property (
        op_valid_i && !byp && !ap_o[5] && orr[1] && !fr[1] |-> op_deny_o)
        else $error("boot operand not blocked");
    a_ee_op_lock: assert property (
        op_valid_i && !byp && !ap_o[4] && orr[2] && fr[2:0] == 3'b000 |-> op_deny_o)
        else $error("eeprom operand not blocked");
    a_ext_fetch_lock: assert property (
        op_valid_i && !byp && !ap_o[3] && orr != 4'h0 && fr == 4'h0 |-> op_deny_o)
        else $error("external fetch reached internal memory");
    a_boot_wr_lock: assert property (
        op_valid_i && op_we_i && !byp && !wp_o[5] && orr[1] |-> op_deny_o)
        else $error("boot write not refused");
    a_ee_wr_lock: assert property (
        op_valid_i && op_we_i && !byp && !wp_o[4] && orr[2] |-> op_deny_o)
        else $error("eeprom write not refused");
    a_test_bypass: assert property (
        op_valid_i && byp |-> !op_deny_o)
        else $error("test mode did not bypass");
    a_dma_blocked: assert property (
        dma_rd_i && dma_deny_o |=> s_dma_ff)
        else $error("denied dma did not return ff");
    a_dma_passes: assert property (
        dma_rd_i && !dma_deny_o |=> dma_rvalid_o && dma_rdata_o == $past(dma_mem_rdata_i))
        else $error("allowed dma data lost");
    a_reset_locked: assert property (
        $fell(reset_i) |-> ap_o[6:3] == 4'h0 && wp_o[5:0] == 6'h00)
        else $error("locks not forced after reset");
    a_ready_load: assert property (
        $fell(reset_i) |-> s_load)
        else $error("ready timing wrong");
    a_pset_refuse: assert property (
        pset_valid_i && ready_o && fr[1:0] != 2'b00 |=> pset_refused_o && $stable(ap_o)
        && $stable(wp_o))
        else $error("pset from flash not refused");
endmodule // nvmpu_checker
bind nvmpu_top nvmpu_checker u_chk (.clk_sys_i, .reset_i, .test_mode_i, .fetch_addr_i,
    .op_valid_i, .op_we_i, .op_addr_i, .pset_valid_i, .dma_rd_i, .dma_mem_rdata_i, .op_deny_o,
    .pset_refused_o, .dma_deny_o, .dma_rvalid_o, .dma_rdata_o, .ap_o, .wp_o, .test_mode_en_o,
    .ready_o);
`default_nettype wire

// [testbench/nvmpu_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module nvmpu_tb_top;
    import nvmpu_pkg::*;
    localparam logic [23:0] F_FL = 24'h00_1000;
    localparam logic [23:0] F_BT = 24'h23_0100;
    localparam logic [23:0] F_EE = 24'h22_0010;
    localparam logic [23:0] F_RAM = 24'h20_0010;
    localparam logic [23:0] F_EXT = 24'h40_0000;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, por_i = 1'b1, test_mode_i = 1'b0, dcfg = 1'b1;
    logic [23:0] fetch = F_RAM, op_addr = '0, dma_addr = '0;
    logic op_valid = 1'b0, op_we = 1'b0, pset_valid = 1'b0, dma_rd = 1'b0;
    logic [7:0] op_wdata = '0, mem_rdata, op_rdata_o, dma_rdata_o, ap_o, wp_o;
    logic [3:0] pset_en = '0;
    logic [31:0] pset_data = '0;
    logic op_deny_o, op_rvalid_o, pset_done_o, pset_refused_o, dma_deny_o, dma_rvalid_o;
    logic op_allow_o, test_mode_en_o, ready_o;
    int n_mismatch = 0, n_checks = 0, cyc = 0;

    nvmpu_top #(.LOAD_N(4)) uut (.clk_sys_i, .reset_i, .por_i, .test_mode_i,
        .direct_unprot_cfg_i(dcfg), .fetch_addr_i(fetch), .op_valid_i(op_valid),
        .op_we_i(op_we), .op_addr_i(op_addr), .op_wdata_i(op_wdata), .pset_valid_i(pset_valid),
        .pset_en_i(pset_en), .pset_data_i(pset_data), .dma_rd_i(dma_rd), .dma_addr_i(dma_addr),
        .dma_mem_rdata_i(mem_rdata), .op_allow_o, .op_deny_o, .op_rvalid_o, .op_rdata_o,
        .pset_done_o, .pset_refused_o, .dma_deny_o, .dma_rvalid_o, .dma_rdata_o, .ap_o, .wp_o,
        .test_mode_en_o, .ready_o);
    nvmpu_mem_model u_mem (.addr_i(dma_addr), .rdata_o(mem_rdata));

    // =====================
    // clock and hang guard
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // whole run is well under 1000 cycles; 3000 leaves room for slow loads
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // =====================
    // access tasks
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // operand access; an allowed read off the register pair returns ff
    task automatic op(input logic [23:0] f, a, input logic we, input logic [7:0] d,
                      input logic edeny);
        @(posedge clk_sys_i);
        fetch <= f;
        op_addr <= a;
        op_we <= we;
        op_wdata <= d;
        op_valid <= 1'b1;
        #1 `CHK({op_allow_o, op_deny_o}, {~edeny, edeny})
        @(posedge clk_sys_i);
        op_valid <= 1'b0;
        #1 if (!we && !edeny) `CHK({op_rvalid_o, op_rdata_o}, 9'h1ff)
    endtask
    task automatic pset(input logic [23:0] f, input logic [3:0] en, input logic [31:0] d,
                        input logic eref);
        @(posedge clk_sys_i);
        fetch <= f;
        pset_en <= en;
        pset_data <= d;
        pset_valid <= 1'b1;
        @(posedge clk_sys_i);
        pset_valid <= 1'b0;
        #1 `CHK({pset_done_o, pset_refused_o}, {~eref, eref})
    endtask
    task automatic dma(input logic [23:0] a, input logic edeny, input logic [7:0] ed);
        @(posedge clk_sys_i);
        dma_addr <= a;
        dma_rd <= 1'b1;
        #1 `CHK(dma_deny_o, edeny)
        @(posedge clk_sys_i);
        dma_rd <= 1'b0;
        #1 `CHK({dma_rvalid_o, dma_rdata_o}, {1'b1, ed})
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 20 && ready_o !== 1'b1; i++)
            @(posedge clk_sys_i) #1;
        #1 `CHK(ready_o, 1'b1)
    endtask

    // =====================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        por_i <= 1'b0;
        wait_ready();
        `CHK(ap_o, DELIVERY)
        `CHK(wp_o, DELIVERY)
        op(F_BT, ADDR_AP, 1'b0, 8'h00, 1'b0);
        dma(24'h00_0040, 1'b0, 8'h1a);
        pset(F_RAM, 4'b0001, 32'h0, 1'b0);
        `CHK(ap_o[6:3], 4'h0)
        op(F_RAM, 24'h00_2000, 1'b0, 8'h00, 1'b1);
        op(F_FL, 24'h00_2000, 1'b0, 8'h00, 1'b0);
        op(F_FL, F_BT, 1'b0, 8'h00, 1'b1);
        op(F_BT, F_BT, 1'b0, 8'h00, 1'b0);
        op(F_RAM, F_EE, 1'b0, 8'h00, 1'b1);
        op(F_FL, F_EE, 1'b0, 8'h00, 1'b0);
        op(F_EXT, F_RAM, 1'b0, 8'h00, 1'b1);
        op(F_RAM, F_RAM, 1'b0, 8'h00, 1'b0);
        dma(24'h00_0040, 1'b1, 8'hff);
        pset(F_FL, 4'b0001, 32'h78, 1'b1);
        pset(F_RAM, 4'b0001, 32'h78, 1'b0);
        `CHK(ap_o[6:3], 4'b0001)
        pset(F_EE, 4'b0001, 32'h78, 1'b0);
        `CHK(ap_o[6:3], 4'b0011)
        op(F_FL, ADDR_AP, 1'b1, 8'h40, 1'b1);
        `CHK(ap_o[6], 1'b1)
        @(posedge clk_sys_i) dcfg <= 1'b0;
        op(F_BT, ADDR_AP, 1'b1, 8'h20, 1'b0);
        `CHK(ap_o[5], 1'b0)
        @(posedge clk_sys_i) dcfg <= 1'b1;
        op(F_BT, ADDR_AP, 1'b1, 8'h20, 1'b0);
        `CHK(ap_o[5], 1'b1)
        op(F_RAM, 24'h00_2000, 1'b0, 8'h00, 1'b0);
        pset(F_RAM, 4'b0001, 32'h0, 1'b0);
        `CHK(ap_o[6:3], 4'h0)
        // write locks: lock all, probe, then lift what may be lifted
        pset(F_RAM, 4'b0010, 32'h0, 1'b0);
        for (int s = 0; s < 4; s++) op(F_FL, {7'h0, s[1:0], 15'h0}, 1'b1, 8'h00, 1'b1);
        op(F_FL, F_EE, 1'b1, 8'h00, 1'b1);
        pset(F_RAM, 4'b0010, 32'h3f00, 1'b0);
        `CHK(wp_o[5:0], 6'h1f)
        for (int s = 0; s < 4; s++) op(F_FL, {7'h0, s[1:0], 15'h0}, 1'b1, 8'h00, 1'b0);
        op(F_FL, F_EE, 1'b1, 8'h00, 1'b0);
        op(F_BT, F_BT, 1'b1, 8'h00, 1'b1);
        pset(F_RAM, 4'b0010, 32'h2f00, 1'b0);
        `CHK(wp_o[5:0], 6'h0f)
        // password and test mode
        @(posedge clk_sys_i) test_mode_i <= 1'b1;
        op(F_RAM, 24'h00_2000, 1'b0, 8'h00, 1'b0);
        pset(F_RAM, 4'b1100, 32'h1234_0000, 1'b0);
        `CHK(wp_o[7:6], 2'b01)
        `CHK(test_mode_en_o, 1'b0)
        op(F_RAM, 24'h00_2000, 1'b0, 8'h00, 1'b1);
        pset(F_RAM, 4'b1100, 32'h0, 1'b0);
        `CHK(ap_o[2:0], 3'b011)
        pset(F_RAM, 4'b1100, 32'h0, 1'b0);
        `CHK(ap_o[2:0], 3'b001)
        pset(F_RAM, 4'b1100, 32'h1234_0000, 1'b0);
        `CHK({wp_o[6], test_mode_en_o}, 2'b01)
        op(F_RAM, 24'h00_2000, 1'b0, 8'h00, 1'b0);
        op(F_BT, ADDR_PWL, 1'b0, 8'h00, 1'b0);
        @(posedge clk_sys_i) test_mode_i <= 1'b0;
        // warm reset in mid-run drops every lift, cells keep their values
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        wait_ready();
        `CHK(ap_o, 8'h81)
        `CHK(wp_o, 8'h00)
        test_done();
    end
endmodule // nvmpu_tb_top
`default_nettype wire
